// [design/psp_defs.svh]
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// sample word layout, lsb is bit zero
`define PSP_WORD_W 12
`define PSP_WORD_LSB 0
`define PSP_WORD_MSB 11
// pair word: first channel low half, second channel high half
`define PSP_PAIR_W 24
`define PSP_FIRST_LSB 0
`define PSP_SECOND_LSB 12
// reset values
`define PSP_WORD_RST 12'h000
`define PSP_PAIR_RST 24'h000000
// buffer depth
`define PSP_BUF_DEPTH 2

`endif

// [design/psp_pkg.sv]
`default_nettype none
`include "psp_defs.svh"

package psp_pkg;
    typedef logic [`PSP_WORD_W-1:0] psp_word_t;
    typedef logic [`PSP_PAIR_W-1:0] psp_pair_t;
    // system side transfer state, one-hot
    typedef enum logic [1:0] {
        PSP_XFER_IDLE = 2'b01,
        PSP_XFER_WAIT = 2'b10
    } psp_xfer_st_t;
endpackage

`default_nettype wire

// [design/psp_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psp_defs.svh"

module psp_port #(
    parameter int BUF_DEPTH = `PSP_BUF_DEPTH
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // sample stream in, one word per channel per beat
    input wire logic smp_valid,
    output logic smp_ready,
    input wire psp_pkg::psp_word_t smp_first_word,
    input wire psp_pkg::psp_word_t smp_second_word,
    // playback control
    input wire logic play_en,
    // converter sample clock
    input wire logic dac_clk,
    // first channel port
    output logic [`PSP_WORD_W-1:0] first_output_channel_sample_word_bits,
    output logic first_output_channel_clk,
    // second channel port
    output logic [`PSP_WORD_W-1:0] second_output_channel_sample_word_bits,
    output logic second_output_channel_clk
);
    import psp_pkg::*;

    localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // two-entry buffer, system domain

    psp_pair_t buf_mem [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] cnt_q;
    logic buf_valid;
    logic buf_pop;
    logic buf_push;
    psp_xfer_st_t xfer_st_q;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        if (p == PTR_W'(BUF_DEPTH - 1)) begin
            return '0;
        end
        return p + PTR_W'(1);
    endfunction

    assign smp_ready = (cnt_q != (PTR_W+1)'(BUF_DEPTH));
    assign buf_valid = (cnt_q != '0);
    assign buf_push = smp_valid && smp_ready;
    assign buf_pop = buf_valid && (xfer_st_q == PSP_XFER_IDLE);

    always_ff @(posedge sys_clk) begin
        if (buf_push) begin
            buf_mem[wr_ptr_q] <= {smp_second_word, smp_first_word};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (buf_push) begin
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            end
            if (buf_pop) begin
                rd_ptr_q <= ptr_inc(rd_ptr_q);
            end
            if (buf_push && !buf_pop) begin
                cnt_q <= cnt_q + (PTR_W+1)'(1);
            end else if (buf_pop && !buf_push) begin
                cnt_q <= cnt_q - (PTR_W+1)'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // toggle handshake toward the converter domain

    psp_pair_t xfer_data_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic ack_tgl_q;
    logic ack_evt;

    assign ack_evt = ack_s2_q ^ ack_s3_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    // data held stable until the far side acknowledges
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            xfer_st_q <= PSP_XFER_IDLE;
            xfer_data_q <= `PSP_PAIR_RST;
            req_tgl_q <= 1'b0;
        end else begin
            case (xfer_st_q)
                PSP_XFER_IDLE: begin
                    if (buf_valid) begin
                        xfer_data_q <= buf_mem[rd_ptr_q];
                        req_tgl_q <= ~req_tgl_q;
                        xfer_st_q <= PSP_XFER_WAIT;
                    end
                end
                PSP_XFER_WAIT: begin
                    if (ack_evt) begin
                        xfer_st_q <= PSP_XFER_IDLE;
                    end
                end
                default: begin
                    xfer_st_q <= PSP_XFER_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter domain: reset release, synchronisers

    logic drst_s1_q;
    logic drst_q;
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic play_s1_q;
    logic play_q;

    always_ff @(posedge dac_clk or posedge rst) begin
        if (rst) begin
            drst_s1_q <= 1'b1;
            drst_q <= 1'b1;
        end else begin
            drst_s1_q <= 1'b0;
            drst_q <= drst_s1_q;
        end
    end

    always_ff @(posedge dac_clk or posedge drst_q) begin
        if (drst_q) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            play_s1_q <= 1'b0;
            play_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            play_s1_q <= play_en;
            play_q <= play_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter domain: word hold, launch and clock gate

    psp_pair_t hold_q;
    logic have_q;
    logic primed_q;
    logic gate_q;
    logic new_req;
    logic take_play;
    logic take_prime;
    logic prime_go;
    psp_word_t first_q;
    psp_word_t second_q;

    assign new_req = req_s2_q ^ req_s3_q;
    assign prime_go = play_q && primed_q;
    assign take_play = play_q && !primed_q && have_q;
    assign take_prime = !play_q && !primed_q && have_q;

    always_ff @(posedge dac_clk or posedge drst_q) begin
        if (drst_q) begin
            hold_q <= `PSP_PAIR_RST;
            have_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            if (new_req) begin
                hold_q <= xfer_data_q;
                have_q <= 1'b1;
            end else if (take_play || take_prime) begin
                have_q <= 1'b0;
                ack_tgl_q <= ~ack_tgl_q;
            end
        end
    end

    always_ff @(posedge dac_clk or posedge drst_q) begin
        if (drst_q) begin
            first_q <= `PSP_WORD_RST;
            second_q <= `PSP_WORD_RST;
        end else if (take_play || take_prime) begin
            first_q <= hold_q[`PSP_FIRST_LSB +: `PSP_WORD_W];
            second_q <= hold_q[`PSP_SECOND_LSB +: `PSP_WORD_W];
        end
    end

    // idle word sits on the lines without a clock until playback starts
    always_ff @(posedge dac_clk or posedge drst_q) begin
        if (drst_q) begin
            primed_q <= 1'b0;
        end else if (take_prime) begin
            primed_q <= 1'b1;
        end else if (prime_go) begin
            primed_q <= 1'b0;
        end
    end

    // one pulse per presented word, none while idle
    always_ff @(posedge dac_clk or posedge drst_q) begin
        if (drst_q) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= take_play || prime_go;
        end
    end

    // pulse rises at mid-word on the falling edge; gate moves while clock high
    assign first_output_channel_clk = gate_q & ~dac_clk;
    assign second_output_channel_clk = gate_q & ~dac_clk;
    assign first_output_channel_sample_word_bits = first_q;
    assign second_output_channel_sample_word_bits = second_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_buf_full_stall: assert property (@(posedge sys_clk) disable iff (rst)
        (!smp_ready && !buf_pop) |=> !smp_ready && (cnt_q <= (PTR_W+1)'(BUF_DEPTH)))
        else $error("full buffer changed without a pop");

    a_word_follows_hold: assert property (@(posedge dac_clk) disable iff (drst_q)
        take_play |=> first_q == $past(hold_q[`PSP_FIRST_LSB +: `PSP_WORD_W]))
        else $error("first channel word not taken from hold");

    a_second_ch_word: assert property (@(posedge dac_clk) disable iff (drst_q)
        (take_play || take_prime)
            |=> second_q == $past(hold_q[`PSP_SECOND_LSB +: `PSP_WORD_W]))
        else $error("second channel word wrong");

    a_data_with_clk: assert property (@(posedge dac_clk) disable iff (drst_q)
        ($changed(first_q) && $past(play_q)) |-> gate_q)
        else $error("word changed in playback without clock pulse");

    a_idle_clk_off: assert property (@(posedge dac_clk) disable iff (drst_q)
        !play_q |=> !gate_q)
        else $error("clock running while idle");

    a_prime_no_clk: assert property (@(posedge dac_clk) disable iff (drst_q)
        take_prime |=> (!gate_q && primed_q) ##1 (primed_q || play_q))
        else $error("primed word emitted a clock or was lost");

    a_start_clocks: assert property (@(posedge dac_clk) disable iff (drst_q)
        (play_q && (primed_q || have_q)) |=> gate_q)
        else $error("playback did not start the clock");

    a_no_stray_pulse: assert property (@(posedge dac_clk) disable iff (drst_q)
        gate_q |-> $past(play_q) && $past(have_q || primed_q))
        else $error("clock pulse without a word");

    c_buf_fill: cover property (@(posedge sys_clk) disable iff (rst)
        cnt_q == (PTR_W+1)'(BUF_DEPTH));
    c_prime_then_play: cover property (@(posedge dac_clk) disable iff (drst_q)
        take_prime ##[1:20] prime_go);
    c_stream: cover property (@(posedge dac_clk) disable iff (drst_q)
        take_play ##[1:8] take_play);

endmodule

`default_nettype wire

// [testbench/psp_latch.sv]
`timescale 1ns/1ps
`default_nettype none

// user side register, one word per forwarded clock rising edge
module psp_latch (
    // forwarded clock and data lines
    input wire logic clk,
    input wire psp_pkg::psp_word_t data
);
    import psp_pkg::*;
    psp_word_t got[$];
    // rising edge falls mid-word, no extra delay line needed
    always @(posedge clk) begin
        got.push_back(data);
    end
endmodule

`default_nettype wire

// [testbench/psp_port_test.sv]
`timescale 1ns/1ps
`default_nettype none

module psp_port_test;
    import psp_pkg::*;
    logic sys_clk = 1'b0;
    logic dac_clk = 1'b0;
    logic rst = 1'b1;
    logic smp_valid = 1'b0;
    logic play_en = 1'b0;
    psp_word_t smp_first_word = 12'h000;
    psp_word_t smp_second_word = 12'h000;
    logic smp_ready;
    psp_word_t first_bits;
    psp_word_t second_bits;
    logic first_clk;
    logic second_clk;
    int miscompares = 0;
    int checked = 0;
    int sent = 0;

    always #2.5 sys_clk = ~sys_clk;
    initial begin
        #7.3;
        forever #32 dac_clk = ~dac_clk;
    end

    psp_port u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .smp_valid(smp_valid),
        .smp_ready(smp_ready),
        .smp_first_word(smp_first_word),
        .smp_second_word(smp_second_word),
        .play_en(play_en),
        .dac_clk(dac_clk),
        .first_output_channel_sample_word_bits(first_bits),
        .first_output_channel_clk(first_clk),
        .second_output_channel_sample_word_bits(second_bits),
        .second_output_channel_clk(second_clk)
    );
    psp_latch u_lat1 (.clk(first_clk), .data(first_bits));
    psp_latch u_lat2 (.clk(second_clk), .data(second_bits));

    ////////////////////////////////////////////////////////////////////////
    function automatic psp_word_t fw(input int i);
        return psp_word_t'(12'h801 + 12'h123 * i);
    endfunction

    task automatic chk(input string what, input psp_word_t exp, input psp_word_t got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // offer one pair, give up after a bounded wait
    task automatic push(input int i, output bit taken);
        int n;
        taken = 1'b0;
        @(posedge sys_clk);
        smp_valid <= 1'b1;
        smp_first_word <= fw(i);
        smp_second_word <= ~fw(i);
        for (n = 0; n < 40 && !taken; n++) begin
            @(posedge sys_clk);
            taken = (smp_ready === 1'b1);
        end
        smp_valid <= 1'b0;
    endtask

    task automatic wait_got(input int n);
        int k;
        for (k = 0; k < 4000 && u_lat1.got.size() < n; k++) begin
            @(posedge sys_clk);
        end
    endtask

    task automatic chk_pulses(input int n);
        chk("pulses first", psp_word_t'(n), psp_word_t'(u_lat1.got.size()));
        chk("pulses second", psp_word_t'(n), psp_word_t'(u_lat2.got.size()));
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("ready", 12'h001, {11'h000, smp_ready});
        chk("first bits", 12'h000, first_bits);
        chk("clocks", 12'h000, {10'h000, first_clk, second_clk});
    endtask

    // word arriving while stopped sits on the lines without a clock
    task automatic t_prime();
        bit taken;
        int k;
        push(0, taken);
        for (k = 0; k < 1000 && first_bits !== fw(0); k++) begin
            @(posedge sys_clk);
        end
        chk("primed first", fw(0), first_bits);
        chk("primed second", ~fw(0), second_bits);
        chk_pulses(0);
    endtask

    // fill until the buffer refuses, still stopped
    task automatic t_fill();
        bit taken;
        taken = 1'b1;
        while (taken && sent < 8) begin
            push(sent + 1, taken);
            if (taken) begin
                sent++;
            end
        end
        chk("refused", 12'h000, {11'h000, taken});
        chk("ready low", 12'h000, {11'h000, smp_ready});
        repeat (2) @(posedge dac_clk);
        chk_pulses(0);
    endtask

    // start play: primed word first, then all held words in order
    task automatic t_play();
        int k;
        bit taken;
        @(posedge sys_clk);
        play_en <= 1'b1;
        wait_got(sent + 1);
        push(sent + 1, taken);
        chk("play taken", 12'h001, {11'h000, taken});
        sent++;
        wait_got(sent + 1);
        repeat (20) @(posedge dac_clk);
        chk_pulses(sent + 1);
        for (k = 0; k <= sent && k < u_lat1.got.size(); k++) begin
            chk("word first", fw(k), u_lat1.got[k]);
            chk("word second", ~fw(k), u_lat2.got[k]);
        end
    endtask

    // stopping freezes the clock and keeps the last word; a later word primes again
    task automatic t_stop();
        int k;
        bit taken;
        @(posedge sys_clk);
        play_en <= 1'b0;
        repeat (4) @(posedge dac_clk);
        wait_got(0);
        repeat (20) @(posedge dac_clk);
        chk_pulses(sent + 1);
        chk("last word", fw(sent), first_bits);
        push(sent + 1, taken);
        chk("stop taken", 12'h001, {11'h000, taken});
        sent++;
        for (k = 0; k < 1000 && first_bits !== fw(sent); k++) begin
            @(posedge sys_clk);
        end
        chk("reprimed first", fw(sent), first_bits);
        chk("reprimed second", ~fw(sent), second_bits);
        chk_pulses(sent);
        @(posedge sys_clk);
        play_en <= 1'b1;
        wait_got(sent + 1);
        repeat (4) @(posedge dac_clk);
        chk_pulses(sent + 1);
        chk("restart word", fw(sent), (u_lat1.got.size() > sent) ? u_lat1.got[sent] : ~fw(sent));
    endtask

    initial begin
        #300000;
        miscompares++;
        give_verdict();
    end

    initial begin
        // ten cycles; converter side follows asynchronously
        repeat (10) @(posedge sys_clk);
        t_reset();
        rst <= 1'b0;
        t_prime();
        t_fill();
        t_play();
        t_stop();
        give_verdict();
    end
endmodule

`default_nettype wire
